// ---- core/dmd_pkg.sv ----
/*
 * Shared constants for the discovery and message decoder: command and
 * message opcodes, type codes, action codes, completion status, sizes.
 * Assumes one controller clock domain; no software-visible registers.
 */
package dmd_pkg;

    ////////////////////////////////////////////////////////////////////
    // Command and message opcodes (byte 0)
    localparam logic [7:0] OP_REPORT_LOG = 8'hC2; // Logical unit list
    localparam logic [7:0] OP_REPORT_PHYS = 8'hC3; // Physical unit list
    localparam logic [7:0] MSG_ABORT = 8'h00;
    localparam logic [7:0] MSG_RESET = 8'h01;
    localparam logic [7:0] MSG_SCAN = 8'h02;
    localparam logic [7:0] MSG_NOOP = 8'h03;

    ////////////////////////////////////////////////////////////////////
    // Type codes (byte 1)
    localparam logic [7:0] AB_TASK = 8'h00;
    localparam logic [7:0] AB_TASK_SET = 8'h01;
    localparam logic [7:0] AB_CLEAR_ACA = 8'h02;
    localparam logic [7:0] AB_CLEAR_SET = 8'h03;
    localparam logic [7:0] TY_ALL = 8'h00; // Controller or all buses
    localparam logic [7:0] TY_BUS = 8'h01;
    localparam logic [7:0] TY_TARGET = 8'h03;
    localparam logic [7:0] TY_LUN = 8'h04;

    ////////////////////////////////////////////////////////////////////
    // Action codes presented on the action port
    localparam logic [3:0] ACT_ABORT_TAG = 4'h1;
    localparam logic [3:0] ACT_ABORT_SET = 4'h2;
    localparam logic [3:0] ACT_CLEAR_ACA = 4'h3;
    localparam logic [3:0] ACT_RST_CTRL = 4'h4;
    localparam logic [3:0] ACT_RST_BUS = 4'h5;
    localparam logic [3:0] ACT_RST_TGT = 4'h6;
    localparam logic [3:0] ACT_RST_LUN = 4'h7;
    localparam logic [3:0] ACT_SCAN_ALL = 4'h8;
    localparam logic [3:0] ACT_SCAN_BUS = 4'h9;
    localparam logic [3:0] ACT_SCAN_TGT = 4'hA;
    localparam logic [3:0] ACT_SCAN_LUN = 4'hB;

    ////////////////////////////////////////////////////////////////////
    // Completion status and response layout
    localparam logic STAT_OK = 1'h0;
    localparam logic STAT_BAD = 1'h1; // Unknown opcode or type
    localparam logic [31:0] HDR_BYTES = 32'h0000_0008; // Length + reserved
    localparam logic [31:0] RSV_FIRST = 32'h0000_0004; // First reserved byte

    // Controller states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STREAM = 3'b010,
        ST_DRAIN = 3'b100
    } dmd_state_t;

endpackage : dmd_pkg

// ---- core/dmd_decoder.sv ----
/*
 * Discovery and message decoder: serves the two unit-list commands as a
 * byte stream and turns abort, reset, scan and no-op messages into
 * actions and completions.
 * Assumes the unit table answers i_unit_entry in the same cycle as
 * o_unit_index, and that the command pool signals i_act_drained once
 * every command hit by an action has completed to the host.
 */
module dmd_decoder #(
    parameter int CW = 16 // Width of unit counts and index
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Request port
    input wire logic i_req_valid,
    input wire logic i_req_is_msg,
    input wire logic [127:0] i_req_bytes,
    input wire logic [63:0] i_req_unit,
    output logic o_req_ready,
    // Unit table lookup
    input wire logic [CW-1:0] i_log_count,
    input wire logic [CW-1:0] i_phys_count,
    input wire logic [63:0] i_unit_entry,
    output logic o_list_phys,
    output logic [CW-1:0] o_unit_index,
    // Response byte stream
    input wire logic i_data_ready,
    output logic o_data_valid,
    output logic [7:0] o_data,
    output logic o_data_last,
    // Action port
    input wire logic i_act_drained,
    output logic o_act_valid,
    output logic [3:0] o_act_code,
    output logic [63:0] o_act_tag,
    output logic [63:0] o_act_unit,
    // Completion
    output logic o_done,
    output logic o_done_status
);

    ////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        dmd_pkg::dmd_state_t state;
        logic [31:0] pos; // Next byte to send
        logic [31:0] limit; // Bytes to send
        logic [31:0] list_len; // Untruncated list length
        logic [31:0] alloc; // Host allocation length
        logic [CW-1:0] count; // Units in chosen list
        logic phys;
        logic dvalid;
        logic [7:0] data;
        logic last;
        logic act;
        logic [3:0] code;
        logic [63:0] tag;
        logic [63:0] unit;
        logic done;
        logic status;
    } dmd_regs_t;

    dmd_regs_t r_reg;
    dmd_regs_t r_next;

    // Request fields
    logic [7:0] op; // Byte 0
    logic [7:0] ty; // Byte 1
    logic [31:0] alloc_len; // Bytes 6-9
    logic [CW-1:0] sel_count; // Count of the requested list
    logic [31:0] total; // Header plus entries
    logic [31:0] off; // Offset into entry area
    logic [63:0] ent_shift; // Entry with wanted byte on top
    logic take;

    assign op = i_req_bytes[7:0];
    assign ty = i_req_bytes[15:8];
    // Byte 6 is most significant
    assign alloc_len = {i_req_bytes[55:48], i_req_bytes[63:56],
                        i_req_bytes[71:64], i_req_bytes[79:72]};
    assign take = i_req_valid && o_req_ready;
    // Phys count comes from a table that already holds masked and bridged devices
    assign sel_count = (op == dmd_pkg::OP_REPORT_PHYS) ? i_phys_count : i_log_count;
    assign total = 32'({sel_count, 3'b000}) + dmd_pkg::HDR_BYTES;
    assign off = r_reg.pos - dmd_pkg::HDR_BYTES;
    // Entry bytes go out most significant first, untouched layout
    assign ent_shift = i_unit_entry << {off[2:0], 3'b000};

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.act = 1'b0;
        r_next.done = 1'b0;
        unique case (r_reg.state)
            dmd_pkg::ST_IDLE: begin
                if (take) begin
                    r_next.unit = i_req_unit;
                    r_next.tag = i_req_bytes[95:32];
                    r_next.status = dmd_pkg::STAT_OK;
                    if (!i_req_is_msg) begin
                        // Discovery commands
                        if (op == dmd_pkg::OP_REPORT_LOG || op == dmd_pkg::OP_REPORT_PHYS) begin
                            r_next.phys = (op == dmd_pkg::OP_REPORT_PHYS);
                            r_next.count = sel_count;
                            r_next.list_len = 32'({sel_count, 3'b000});
                            r_next.alloc = alloc_len;
                            r_next.limit = (alloc_len < total) ? alloc_len : total;
                            r_next.pos = 32'h0000_0000;
                            r_next.state = dmd_pkg::ST_STREAM;
                        end else begin
                            r_next.done = 1'b1;
                            r_next.status = dmd_pkg::STAT_BAD;
                        end
                    end else begin
                        // Messages; reserved bytes are never looked at
                        r_next.done = 1'b1;
                        unique case (op)
                            dmd_pkg::MSG_ABORT: begin
                                r_next.act = 1'b1;
                                unique case (ty)
                                    dmd_pkg::AB_TASK: r_next.code = dmd_pkg::ACT_ABORT_TAG;
                                    dmd_pkg::AB_TASK_SET, dmd_pkg::AB_CLEAR_SET:
                                        r_next.code = dmd_pkg::ACT_ABORT_SET;
                                    // The controller keeps no ACA; pass it to the device
                                    dmd_pkg::AB_CLEAR_ACA: r_next.code = dmd_pkg::ACT_CLEAR_ACA;
                                    default: begin
                                        r_next.act = 1'b0;
                                        r_next.status = dmd_pkg::STAT_BAD;
                                    end
                                endcase
                            end
                            dmd_pkg::MSG_RESET: begin
                                r_next.act = 1'b1;
                                unique case (ty)
                                    dmd_pkg::TY_ALL: r_next.code = dmd_pkg::ACT_RST_CTRL;
                                    dmd_pkg::TY_BUS: r_next.code = dmd_pkg::ACT_RST_BUS;
                                    dmd_pkg::TY_TARGET: r_next.code = dmd_pkg::ACT_RST_TGT;
                                    dmd_pkg::TY_LUN: r_next.code = dmd_pkg::ACT_RST_LUN;
                                    default: begin
                                        r_next.act = 1'b0;
                                        r_next.status = dmd_pkg::STAT_BAD;
                                    end
                                endcase
                            end
                            dmd_pkg::MSG_SCAN: begin
                                // Probe only; results reach the host by discovery
                                r_next.act = 1'b1;
                                unique case (ty)
                                    dmd_pkg::TY_ALL: r_next.code = dmd_pkg::ACT_SCAN_ALL;
                                    dmd_pkg::TY_BUS: r_next.code = dmd_pkg::ACT_SCAN_BUS;
                                    dmd_pkg::TY_TARGET: r_next.code = dmd_pkg::ACT_SCAN_TGT;
                                    dmd_pkg::TY_LUN: r_next.code = dmd_pkg::ACT_SCAN_LUN;
                                    default: begin
                                        r_next.act = 1'b0;
                                        r_next.status = dmd_pkg::STAT_BAD;
                                    end
                                endcase
                            end
                            dmd_pkg::MSG_NOOP: r_next.status = dmd_pkg::STAT_OK;
                            default: r_next.status = dmd_pkg::STAT_BAD;
                        endcase
                        // Aborts other than ACA clears, and resets, hold completion until drained
                        if (r_next.act && r_next.code != dmd_pkg::ACT_CLEAR_ACA
                            && r_next.code < dmd_pkg::ACT_SCAN_ALL) begin
                            r_next.done = 1'b0;
                            r_next.state = dmd_pkg::ST_DRAIN;
                        end
                    end
                end
            end
            dmd_pkg::ST_STREAM: begin
                if (!r_reg.dvalid || i_data_ready) begin
                    if (r_reg.pos < r_reg.limit) begin
                        r_next.dvalid = 1'b1;
                        r_next.pos = r_reg.pos + 32'h0000_0001;
                        r_next.last = (r_next.pos == r_reg.limit);
                        // Header first, then entries
                        if (r_reg.pos < dmd_pkg::RSV_FIRST) begin
                            r_next.data = 8'(r_reg.list_len >> {~r_reg.pos[1:0], 3'b000});
                        end else if (r_reg.pos < dmd_pkg::HDR_BYTES) begin
                            r_next.data = 8'h00;
                        end else begin
                            r_next.data = ent_shift[63:56];
                        end
                    end else begin
                        // Last byte taken or nothing allowed
                        r_next.dvalid = 1'b0;
                        r_next.last = 1'b0;
                        r_next.done = 1'b1;
                        r_next.state = dmd_pkg::ST_IDLE;
                    end
                end
            end
            dmd_pkg::ST_DRAIN: begin
                // Completion only after every hit command is back
                if (i_act_drained) begin
                    r_next.done = 1'b1;
                    r_next.state = dmd_pkg::ST_IDLE;
                end
            end
            default: r_next.state = dmd_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            r_reg <= '0;
            r_reg.state <= dmd_pkg::ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_req_ready = (r_reg.state == dmd_pkg::ST_IDLE);
    assign o_list_phys = r_reg.phys;
    assign o_unit_index = off[CW+2:3];
    assign o_data_valid = r_reg.dvalid;
    assign o_data = r_reg.data;
    assign o_data_last = r_reg.last;
    assign o_act_valid = r_reg.act;
    assign o_act_code = r_reg.code;
    assign o_act_tag = r_reg.tag;
    assign o_act_unit = r_reg.unit;
    assign o_done = r_reg.done;
    assign o_done_status = r_reg.status;

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_len_msb;
        @(posedge i_clock) disable iff (!i_resetn)
        (o_data_valid && r_reg.pos == 32'h0000_0001) |-> o_data == r_reg.list_len[31:24];
    endproperty
    a_len_msb: assert property (p_len_msb) else $error("first byte not length MSB");

    property p_rsv_zero;
        @(posedge i_clock) disable iff (!i_resetn)
        (o_data_valid && r_reg.pos > 32'h0000_0004 && r_reg.pos < 32'h0000_0009) |-> o_data == 8'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved header byte nonzero");

    property p_len_full;
        @(posedge i_clock) disable iff (!i_resetn)
        (r_reg.state == dmd_pkg::ST_STREAM) |-> r_reg.list_len == 32'({r_reg.count, 3'b000});
    endproperty
    a_len_full: assert property (p_len_full) else $error("list length not eight per unit");

    property p_alloc_cap;
        @(posedge i_clock) disable iff (!i_resetn)
        o_data_valid |-> r_reg.pos <= r_reg.alloc;
    endproperty
    a_alloc_cap: assert property (p_alloc_cap) else $error("sent past allocation length");

    property p_log_list;
        @(posedge i_clock) disable iff (!i_resetn)
        (take && !i_req_is_msg && op == dmd_pkg::OP_REPORT_LOG) |=> !o_list_phys;
    endproperty
    a_log_list: assert property (p_log_list) else $error("logical report chose physical list");

    property p_noop_ok;
        @(posedge i_clock) disable iff (!i_resetn)
        (take && i_req_is_msg && op == dmd_pkg::MSG_NOOP) |=> o_done && o_done_status == dmd_pkg::STAT_OK;
    endproperty
    a_noop_ok: assert property (p_noop_ok) else $error("no-op did not succeed");

    property p_drain_hold;
        @(posedge i_clock) disable iff (!i_resetn)
        (r_reg.state == dmd_pkg::ST_DRAIN && !i_act_drained) |=> !o_done;
    endproperty
    a_drain_hold: assert property (p_drain_hold) else $error("completion before drain");

    property p_clear_set;
        @(posedge i_clock) disable iff (!i_resetn)
        (take && i_req_is_msg && op == dmd_pkg::MSG_ABORT && ty == dmd_pkg::AB_CLEAR_SET)
        |=> o_act_valid && o_act_code == dmd_pkg::ACT_ABORT_SET;
    endproperty
    a_clear_set: assert property (p_clear_set) else $error("clear set differs from abort set");

    sequence s_scan_lun;
        take && i_req_is_msg && op == dmd_pkg::MSG_SCAN && ty == dmd_pkg::TY_LUN;
    endsequence
    sequence s_scan_out;
        o_act_valid && o_act_code == dmd_pkg::ACT_SCAN_LUN && o_done ##1 o_req_ready;
    endsequence
    property p_scan_lun;
        @(posedge i_clock) disable iff (!i_resetn)
        s_scan_lun |=> s_scan_out;
    endproperty
    a_scan_lun: assert property (p_scan_lun) else $error("unit scan not issued");

endmodule : dmd_decoder

// ---- dv/dmd_env_model.sv ----
/*
 * Far-side model of the decoder: unit table, response byte sink and
 * command pool that reports when an abort or reset has drained.
 * Assumes one clock shared with the decoder and its active-low reset.
 */
module dmd_env_model (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Unit table lookup
    input wire logic i_list_phys,
    input wire logic [15:0] i_unit_index,
    output logic [63:0] o_unit_entry,
    // Stream sink and command pool
    input wire logic i_stall,
    input wire logic i_act_valid,
    input wire logic [3:0] i_act_code,
    input wire logic [3:0] i_drain_delay,
    output logic o_data_ready,
    output logic o_act_drained
);
    timeunit 1ns;
    timeprecision 1ps;

    logic toggle_reg; // Alternating ready while stalling
    logic [3:0] count_reg; // Cycles left until the pool has drained

    ////////////////////////////////////////////////////////////////////
    // Entry marks its list in its top byte, so a wrong list choice shows in the first byte of every entry
    assign o_unit_entry = {i_list_phys ? 8'hB3 : 8'hA2, 8'h00, 32'h0000_0000, i_unit_index};
    assign o_data_ready = !i_stall || toggle_reg;

    ////////////////////////////////////////////////////////////////////
    // Drain is slow on purpose: a decoder that skips the wait is caught
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            toggle_reg <= 1'b0;
            count_reg <= 4'h0;
            o_act_drained <= 1'b0;
        end else begin
            toggle_reg <= !toggle_reg;
            o_act_drained <= (count_reg == 4'h1);
            // Only aborts and resets hit pool commands; scans and ACA clears leave no drain behind
            if (i_act_valid && i_act_code inside {dmd_pkg::ACT_ABORT_TAG, dmd_pkg::ACT_ABORT_SET,
                dmd_pkg::ACT_RST_CTRL, dmd_pkg::ACT_RST_BUS, dmd_pkg::ACT_RST_TGT, dmd_pkg::ACT_RST_LUN}) begin
                count_reg <= i_drain_delay;
            end else if (count_reg != 4'h0) begin
                count_reg <= count_reg - 4'h1;
            end
        end
    end
endmodule : dmd_env_model

// ---- dv/tb_discovery_and_message_decoder.sv ----
/*
 * Self-checking bench for the discovery and message decoder.
 * Assumes the far-side model in dmd_env_model; inputs change at falling edges.
 */
module tb_discovery_and_message_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic msg; logic [7:0] op; logic [7:0] ty; int cnt; logic [31:0] alloc;
        logic [3:0] code; logic act; logic stat; logic drain;} dmd_row_t;

    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic req_valid = 1'b0, req_is_msg = 1'b0, stall = 1'b0;
    logic [127:0] req_bytes = '0;
    logic [63:0] req_unit = '0;
    logic [15:0] log_count = '0, phys_count = '0;
    logic [3:0] drain_delay = 4'h5;
    logic o_req_ready, o_list_phys, data_ready, o_data_valid, o_data_last, act_drained;
    logic o_act_valid, o_done, o_done_status;
    logic [63:0] unit_entry, o_act_tag, o_act_unit;
    logic [15:0] o_unit_index;
    logic [7:0] o_data;
    logic [3:0] o_act_code;
    int fail_count = 0;
    int tests_run = 0;

    // Ordinary cases: discovery, every message code and type, unknown codes
    dmd_row_t rows[22] = '{
        '{0, 8'hC2, 8'h00, 2, 32'h0000_0064, 4'h0, 0, 0, 0}, '{0, 8'hC3, 8'h00, 2, 32'h0000_0064, 4'h0, 0, 0, 0},
        '{0, 8'hC2, 8'h00, 3, 32'h0000_000D, 4'h0, 0, 0, 0}, '{0, 8'hC3, 8'h00, 1, 32'h0000_0000, 4'h0, 0, 0, 0},
        '{0, 8'hC2, 8'h00, 0, 32'h0000_0064, 4'h0, 0, 0, 0}, '{0, 8'h12, 8'h00, 1, 32'h0000_0064, 4'h0, 0, 1, 0},
        '{1, 8'h00, 8'h00, 0, 0, 4'h1, 1, 0, 1}, '{1, 8'h00, 8'h01, 0, 0, 4'h2, 1, 0, 1},
        '{1, 8'h00, 8'h02, 0, 0, 4'h3, 1, 0, 0}, '{1, 8'h00, 8'h03, 0, 0, 4'h2, 1, 0, 1},
        '{1, 8'h01, 8'h00, 0, 0, 4'h4, 1, 0, 1}, '{1, 8'h01, 8'h01, 0, 0, 4'h5, 1, 0, 1},
        '{1, 8'h01, 8'h03, 0, 0, 4'h6, 1, 0, 1}, '{1, 8'h01, 8'h04, 0, 0, 4'h7, 1, 0, 1},
        '{1, 8'h02, 8'h00, 0, 0, 4'h8, 1, 0, 0}, '{1, 8'h02, 8'h01, 0, 0, 4'h9, 1, 0, 0},
        '{1, 8'h02, 8'h03, 0, 0, 4'hA, 1, 0, 0}, '{1, 8'h02, 8'h04, 0, 0, 4'hB, 1, 0, 0},
        '{1, 8'h03, 8'h00, 0, 0, 4'h0, 0, 0, 0}, '{1, 8'h01, 8'h02, 0, 0, 4'h0, 0, 1, 0},
        '{1, 8'h04, 8'h00, 0, 0, 4'h0, 0, 1, 0}, '{1, 8'h00, 8'h04, 0, 0, 4'h0, 0, 1, 0}};

    dmd_decoder #(.CW(16)) i_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_req_valid(req_valid),
        .i_req_is_msg(req_is_msg), .i_req_bytes(req_bytes), .i_req_unit(req_unit), .o_req_ready(o_req_ready),
        .i_log_count(log_count), .i_phys_count(phys_count), .i_unit_entry(unit_entry),
        .o_list_phys(o_list_phys), .o_unit_index(o_unit_index), .i_data_ready(data_ready),
        .o_data_valid(o_data_valid), .o_data(o_data), .o_data_last(o_data_last), .i_act_drained(act_drained),
        .o_act_valid(o_act_valid), .o_act_code(o_act_code), .o_act_tag(o_act_tag), .o_act_unit(o_act_unit),
        .o_done(o_done), .o_done_status(o_done_status));

    dmd_env_model i_model (.i_clock(i_clock), .i_resetn(i_resetn), .i_list_phys(o_list_phys),
        .i_unit_index(o_unit_index), .o_unit_entry(unit_entry), .i_stall(stall), .i_act_valid(o_act_valid),
        .i_act_code(o_act_code),
        .i_drain_delay(drain_delay), .o_data_ready(data_ready), .o_act_drained(act_drained));

    ////////////////////////////////////////////////////////////////////
    // Clock, 10 ns period
    initial begin
        forever #5 i_clock = !i_clock;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // Expected response byte k: length MSB first, four zero bytes, entries MSB first
    function automatic logic [7:0] exp_byte(input int k, input int cnt, input logic phys);
        logic [31:0] len;
        logic [63:0] entry;
        len = 32'(8 * cnt);
        entry = {phys ? 8'hB3 : 8'hA2, 8'h00, 32'h0000_0000, 16'((k - 8) / 8)};
        if (k < 4) return len[31 - 8 * k -: 8];
        if (k < 8) return 8'h00;
        return entry[63 - 8 * ((k - 8) % 8) -: 8];
    endfunction : exp_byte

    ////////////////////////////////////////////////////////////////////
    // One request from raise to completion, checking everything seen
    task automatic run(input dmd_row_t r, input int idx);
        logic [63:0] unit;
        logic phys, done, saw_act, saw_drn;
        int cnt, total, n, got;
        unit = 64'h5A00_0000_0000_0000 | 64'(idx);
        phys = (r.op == 8'hC3);
        cnt = phys ? r.cnt + 1 : r.cnt;
        total = (r.alloc < 32'(8 + 8 * cnt)) ? int'(r.alloc) : 8 + 8 * cnt;
        done = 1'b0;
        saw_act = 1'b0;
        saw_drn = 1'b0;
        got = 0;
        @(negedge i_clock);
        chk("ready", 64'h1, 64'(o_req_ready));
        // Reserved bytes left zero, tag only for a single-command abort
        req_bytes = '0;
        req_bytes[15:0] = {r.ty, r.op};
        for (int j = 0; j < 4; j++) req_bytes[8 * (6 + j) +: 8] = r.alloc[31 - 8 * j -: 8];
        if (r.msg && r.op == 8'h00 && r.ty == 8'h00) req_bytes[95:32] = 64'h0123_4567_89AB_CDEF;
        req_is_msg = r.msg;
        req_unit = unit;
        log_count = 16'(r.cnt);
        phys_count = 16'(r.cnt + 1);
        req_valid = 1'b1;
        for (n = 0; n < 500 && !done; n++) begin
            @(negedge i_clock);
            req_valid = 1'b0;
            if (act_drained) saw_drn = 1'b1;
            if (o_act_valid) begin
                saw_act = 1'b1;
                chk("act code", 64'(r.code), 64'(o_act_code));
                chk("act unit", unit, o_act_unit);
                if (r.code == 4'h1) chk("act tag", 64'h0123_4567_89AB_CDEF, o_act_tag);
            end
            if (o_data_valid && data_ready) begin
                chk("data", 64'(exp_byte(got, cnt, phys)), 64'(o_data));
                got++;
                chk("last", 64'(got == total), 64'(o_data_last));
            end
            if (o_done) begin
                done = 1'b1;
                chk("status", 64'(r.stat), 64'(o_done_status));
                chk("drained first", 64'(r.drain), 64'(saw_drn));
                if (r.msg && !r.drain) chk("latency", 64'h0, 64'(n));
            end
        end
        chk("done", 64'h1, 64'(done));
        chk("action", 64'(r.act), 64'(saw_act));
        if (!r.msg && !r.stat) chk("byte count", 64'(total), 64'(got));
        $display("test %0d done", idx);
    endtask : run

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs a few hundred cycles
    initial begin
        #300us;
        fail_count++;
        $display("watchdog expired");
        results();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence: table first, then stall, fast drain and reset cases
    initial begin
        repeat (16) @(negedge i_clock);
        chk("ready in reset", 64'h1, 64'(o_req_ready));
        i_resetn = 1'b1;
        foreach (rows[i]) run(rows[i], i);
        stall = 1'b1;
        run(rows[1], 30);
        stall = 1'b0;
        drain_delay = 4'h1;
        run(rows[11], 31);
        drain_delay = 4'h5;
        // Reset arriving in the middle of a stream must clear it
        @(negedge i_clock);
        req_bytes = '0;
        req_bytes[79:0] = {8'h64, 24'h00_0000, 40'h0, 8'hC3};
        req_is_msg = 1'b0;
        req_valid = 1'b1;
        @(negedge i_clock);
        req_valid = 1'b0;
        repeat (4) @(negedge i_clock);
        i_resetn = 1'b0;
        @(negedge i_clock);
        chk("reset ready", 64'h1, 64'(o_req_ready));
        chk("reset valid", 64'h0, 64'({o_data_valid, o_done, o_act_valid}));
        i_resetn = 1'b1;
        $display("test reset done");
        run(rows[18], 32);
        results();
    end
endmodule : tb_discovery_and_message_decoder
